// ---- hdl/acc_pkg.sv ----
// Contract
// - Software writing one to the go flag starts a conversion.
// - Hardware clears the go flag when the conversion finishes.
// - Completion sets the done flag in the peripheral flag register.
// - Interrupt requested only when converter, peripheral and global enables are set.
// - Clearing the go flag during a conversion aborts it.
// - An abort leaves the result unchanged.
// - After abort, wait two bit periods; software must not restart meanwhile.
// - After the abort wait, acquisition restarts on the selected channel automatically.
// - After completion, keep the sampling switch open one bit period.
// - Each completed conversion places an 8-bit result in the result register.
`default_nettype none
package acc_pkg;
  localparam int RES_W        = 8;
  localparam int CH_W         = 3;
  localparam int DIV_W        = 8;
  localparam int CNV_PERIODS  = 9;
  localparam int ABORT_WAIT   = 2;
  localparam int HOLD_WAIT    = 1;
  localparam logic [DIV_W-1:0] RC_DIV = 8'h04;
  localparam logic [RES_W-1:0] RES_RST = 8'h00;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_CONV  = 2'b01,
    ACC_ABORT = 2'b10,
    ACC_HOLD  = 2'b11
  } acc_state_t;

  typedef struct packed {
    logic             wr;
    logic             go;
    logic             done_clr;
    logic             res_wr;
    logic [RES_W-1:0] res_wdata;
  } acc_sw_t;

  typedef struct packed {
    logic conv_ie;
    logic periph_ie;
    logic global_ie;
  } acc_ie_t;

  typedef struct packed {
    acc_state_t       st;
    logic [DIV_W-1:0] div;
    logic [3:0]       per;
    logic             go;
    logic             done;
    logic             irq;
    logic             sample;
    logic [CH_W-1:0]  ch;
    logic [RES_W-1:0] res;
    logic [RES_W-1:0] sar;
  } acc_reg_t;
endpackage : acc_pkg
`default_nettype wire

// ---- hdl/acc_conversion_control.sv ----
`default_nettype none
module acc_conversion_control
  import acc_pkg::*;
(
  input  wire logic                    CLOCK,      // System clock, 250 MHz.
  input  wire logic                    RST,        // Synchronous reset, active high.
  input  wire logic                    ENABLE,     // Converter switched on.
  input  wire logic                    CLK_SEL_RC, // Use internal RC bit clock divider.
  input  wire logic [acc_pkg::DIV_W-1:0] CLK_DIV,  // System clocks per bit period.
  input  wire logic [acc_pkg::CH_W-1:0] CHANNEL,   // Selected analog input.
  input  wire acc_pkg::acc_sw_t        SW,         // Software writes.
  input  wire acc_pkg::acc_ie_t        IE,         // Interrupt enables.
  input  wire logic                    CMP_BIT,    // Comparator decision for current bit.
  output logic                         GO,         // Go flag readback.
  output logic                         DONE,       // Conversion done flag.
  output logic                         IRQ,        // Interrupt request.
  output logic                         SAMPLE,     // Sampling switch closed.
  output logic [acc_pkg::CH_W-1:0]     MUX_CH,     // Channel to multiplexer.
  output logic [acc_pkg::RES_W-1:0]    RESULT      // Conversion result.
);
  import acc_pkg::*;

  // All sequencer state, approximation register included, lives in one struct.
  acc_reg_t         acc_r;
  acc_reg_t         acc_nxt;
  logic [DIV_W-1:0] div_lim;
  logic             tick;
  logic             sw_start;
  logic             sw_abort;
  logic             irq_gate;
  logic             bit_slot;
  logic             last_slot;

  // A zero divider would tick only once every 256 clocks, so it is raised to one clock per bit period.
  assign div_lim   = CLK_SEL_RC ? RC_DIV
                   : ((CLK_DIV == '0) ? DIV_W'(1) : CLK_DIV);
  assign tick      = (acc_r.div >= div_lim - DIV_W'(1));
  assign sw_start  = SW.wr && SW.go && ENABLE;
  // Dropping the enable mid-conversion is treated like a software abort.
  assign sw_abort  = (SW.wr && !SW.go) || !ENABLE;
  assign irq_gate  = IE.conv_ie && IE.periph_ie && IE.global_ie;
  assign bit_slot  = (acc_r.per >= 4'h1) && (acc_r.per <= 4'(RES_W));
  assign last_slot = (acc_r.per == 4'(CNV_PERIODS - 1));

  always_comb begin
    acc_nxt     = acc_r;
    acc_nxt.div = tick ? '0 : acc_r.div + DIV_W'(1);
    acc_nxt.ch  = CHANNEL;
    // A clear is applied first so that a completion in the same cycle wins.
    if (SW.done_clr) begin
      acc_nxt.done = 1'b0;
    end
    if (SW.res_wr) begin
      acc_nxt.res = SW.res_wdata;
    end
    case (acc_r.st)
      ACC_IDLE: begin
        acc_nxt.sample = ENABLE;
        if (sw_start) begin
          acc_nxt.go     = 1'b1;
          acc_nxt.st     = ACC_CONV;
          acc_nxt.per    = '0;
          acc_nxt.sample = 1'b0;
          acc_nxt.sar    = '0;
          acc_nxt.div    = '0;
        end
      end
      ACC_CONV: begin
        if (sw_abort) begin
          // The partial code stays in the approximation register only.
          acc_nxt.go  = 1'b0;
          acc_nxt.st  = ACC_ABORT;
          acc_nxt.per = '0;
          acc_nxt.div = '0;
        end else if (tick) begin
          acc_nxt.per = acc_r.per + 4'h1;
          if (bit_slot) begin
            acc_nxt.sar[RES_W - int'(acc_r.per)] = CMP_BIT;
          end
          if (last_slot) begin
            // The last decision lands in this cycle, so the updated code is taken.
            acc_nxt.go   = 1'b0;
            acc_nxt.done = 1'b1;
            acc_nxt.res  = acc_nxt.sar;
            acc_nxt.st   = ACC_HOLD;
            acc_nxt.per  = '0;
          end
        end
      end
      ACC_ABORT: begin
        if (tick) begin
          acc_nxt.per = acc_r.per + 4'h1;
          if (acc_r.per == 4'(ABORT_WAIT - 1)) begin
            acc_nxt.st     = ACC_IDLE;
            acc_nxt.sample = ENABLE;
          end
        end
      end
      ACC_HOLD: begin
        acc_nxt.sample = 1'b0;
        if (tick && acc_r.per == 4'(HOLD_WAIT - 1)) begin
          acc_nxt.st     = ACC_IDLE;
          acc_nxt.sample = ENABLE;
        end
      end
      default: begin
        acc_nxt.st = ACC_IDLE;
      end
    endcase
    acc_nxt.irq = acc_nxt.done && irq_gate;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      acc_r <= '{st: ACC_IDLE, div: '0, per: '0, go: 1'b0, done: 1'b0, irq: 1'b0,
                 sample: 1'b0, ch: '0, res: RES_RST, sar: '0};
    end else begin
      acc_r <= acc_nxt;
    end
  end

  assign GO     = acc_r.go;
  assign DONE   = acc_r.done;
  assign IRQ    = acc_r.irq;
  assign SAMPLE = acc_r.sample;
  assign MUX_CH = acc_r.ch;
  assign RESULT = acc_r.res;

  property p_done_clears_go;
    @(posedge CLOCK) disable iff (RST)
      $rose(acc_r.done) |-> !acc_r.go && acc_r.st == ACC_HOLD;
  endproperty
  a_done_clears_go: assert property (p_done_clears_go) else $error("go not cleared");

  property p_go_tracks;
    @(posedge CLOCK) disable iff (RST)
      acc_r.go == (acc_r.st == ACC_CONV);
  endproperty
  a_go_tracks: assert property (p_go_tracks) else $error("go flag out of step");

  property p_start;
    @(posedge CLOCK) disable iff (RST)
      (acc_r.st == ACC_IDLE && SW.wr && SW.go && ENABLE) |=> acc_r.go && acc_r.st == ACC_CONV;
  endproperty
  a_start: assert property (p_start) else $error("conversion not started");

  property p_abort_keeps;
    @(posedge CLOCK) disable iff (RST)
      (acc_r.st == ACC_CONV && SW.wr && !SW.go && !SW.res_wr) |=> acc_r.st == ACC_ABORT
        && $stable(acc_r.res);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed result");

  property p_enable_abort;
    @(posedge CLOCK) disable iff (RST)
      (acc_r.st == ACC_CONV && !ENABLE) |=> acc_r.st == ACC_ABORT && !acc_r.go;
  endproperty
  a_enable_abort: assert property (p_enable_abort) else $error("enable drop not aborted");

  property p_irq;
    @(posedge CLOCK) disable iff (RST)
      acc_r.irq == (acc_r.done && $past(IE.conv_ie && IE.periph_ie && IE.global_ie));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_irq_needs_done;
    @(posedge CLOCK) disable iff (RST)
      acc_r.irq |-> acc_r.done;
  endproperty
  a_irq_needs_done: assert property (p_irq_needs_done) else $error("irq without done");

  property p_hold_open;
    @(posedge CLOCK) disable iff (RST)
      acc_r.st == ACC_HOLD |-> !acc_r.sample;
  endproperty
  a_hold_open: assert property (p_hold_open) else $error("switch closed in hold");

  // The shortest abort wait is two clocks, with a divider of one.
  property p_abort_no_sample;
    @(posedge CLOCK) disable iff (RST)
      $rose(acc_r.st == ACC_ABORT) |-> (acc_r.st == ACC_ABORT && !acc_r.sample)[*2];
  endproperty
  a_abort_no_sample: assert property (p_abort_no_sample) else $error("abort wait short");

  // A start arriving during either wait must leave the go flag low.
  property p_busy_refuse;
    @(posedge CLOCK) disable iff (RST)
      (acc_r.st == ACC_ABORT || acc_r.st == ACC_HOLD) && sw_start |=> !acc_r.go;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("start taken while busy");

  property p_auto_acquire;
    @(posedge CLOCK) disable iff (RST)
      $past(acc_r.st == ACC_ABORT) && acc_r.st == ACC_IDLE && $past(ENABLE) |-> acc_r.sample;
  endproperty
  a_auto_acquire: assert property (p_auto_acquire) else $error("no acquisition after abort");

  property p_mux_follow;
    @(posedge CLOCK) disable iff (RST)
      !$past(RST) |-> acc_r.ch == $past(CHANNEL);
  endproperty
  a_mux_follow: assert property (p_mux_follow) else $error("channel not passed on");

  property p_done_sticky;
    @(posedge CLOCK) disable iff (RST)
      (acc_r.done && !SW.done_clr) |=> acc_r.done;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done dropped");

  // The result carries the seven earlier decisions and the one taken at completion.
  property p_result_load;
    @(posedge CLOCK) disable iff (RST)
      $rose(acc_r.done) |-> acc_r.res == {$past(acc_r.sar[RES_W-1:1]), $past(CMP_BIT)};
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  property p_div_wrap;
    @(posedge CLOCK) disable iff (RST)
      tick |=> acc_r.div == '0;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("bit period divider not wrapped");
endmodule : acc_conversion_control
`default_nettype wire

// ---- testbench/acc_sh_model.sv ----
`default_nettype none
module acc_sh_model
  import acc_pkg::*;
(
  input  wire logic                    clock,  // System clock.
  input  wire logic                    go,     // Conversion running.
  input  wire logic [acc_pkg::CH_W-1:0] mux_ch, // Selected channel.
  input  wire logic [acc_pkg::DIV_W-1:0] period, // System clocks per bit period.
  output logic                         cmp_bit // Comparator decision.
);
  timeunit 1ns;
  timeprecision 1ps;
  int               cnt = 0;
  int               idx;
  logic [RES_W-1:0] code;
  always @(posedge clock) cnt <= go ? cnt + 1 : 0;
  assign code = 8'ha5 ^ {5'h00, mux_ch};
  assign idx  = cnt / period;
  // One decision per bit period, most significant first, read on its last clock.
  assign cmp_bit = (idx >= 1 && idx <= 8) ? code[8 - idx] : ~code[0];
endmodule // acc_sh_model
`default_nettype wire

// ---- testbench/acc_conversion_control_test.sv ----
`default_nettype none
module acc_conversion_control_test
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             CLOCK = 1'b0, RST = 1'b1, ENABLE = 1'b0, CLK_SEL_RC = 1'b1;
  logic [DIV_W-1:0] CLK_DIV = 8'h04, PERIOD = 8'h04;
  logic             GO, DONE, IRQ, SAMPLE, CMP_BIT;
  logic [CH_W-1:0]  CHANNEL = 3'h3, MUX_CH;
  logic [RES_W-1:0] RESULT, last;
  acc_sw_t          SW = '0;
  acc_ie_t          IE = 3'h7;
  int               err_count = 0, n_checks = 0, cyc = 0;
  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("unexpected %0t timeout", $time);
      final_report();
    end
  end
  acc_conversion_control u_acc_conversion_control (.CLOCK(CLOCK), .RST(RST), .ENABLE(ENABLE),
    .CLK_SEL_RC(CLK_SEL_RC), .CLK_DIV(CLK_DIV), .CHANNEL(CHANNEL), .SW(SW), .IE(IE),
    .CMP_BIT(CMP_BIT), .GO(GO), .DONE(DONE), .IRQ(IRQ), .SAMPLE(SAMPLE), .MUX_CH(MUX_CH),
    .RESULT(RESULT));
  acc_sh_model u_acc_sh_model (.clock(CLOCK), .go(GO), .mux_ch(MUX_CH), .period(PERIOD),
    .cmp_bit(CMP_BIT));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic sw(input logic w, g, c, r, input logic [7:0] d);
    @(negedge CLOCK) SW = '{w, g, c, r, d};
    @(negedge CLOCK) SW = '0;
  endtask
  task automatic conv(input logic [2:0] ie);
    IE = ie;
    sw(1, 1, 0, 0, 8'h00);
    chk({7'h00, GO}, 8'h01);
    for (int i = 0; i < 60 && GO !== 1'b0; i++) @(negedge CLOCK);
    last = 8'ha5 ^ {5'h00, CHANNEL};
    chk({7'h00, GO}, 8'h00);
    chk({7'h00, DONE}, 8'h01);
    chk(RESULT, last);
    chk({7'h00, SAMPLE}, 8'h00);
    @(negedge CLOCK);
    chk({7'h00, IRQ}, {7'h00, &ie});
    repeat (6) @(negedge CLOCK);
    chk({7'h00, SAMPLE}, 8'h01);
    sw(0, 0, 1, 0, 8'h00);
    @(negedge CLOCK);
    chk({6'h00, DONE, IRQ}, 8'h00);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge CLOCK);
    RST = 1'b0;
    chk({GO, DONE, IRQ, SAMPLE, MUX_CH, 1'b0}, 8'h00);
    ENABLE = 1'b1; // Converter on well before the first start.
    for (int i = 0; i < 4; i++) begin
      CHANNEL = 3'h3 + 3'(2 * i);
      repeat (20) @(negedge CLOCK); // Acquisition time after channel change.
      conv(3'h7 ^ (3'h7 & (3'h1 << i)));
    end
    sw(1, 1, 0, 0, 8'h00);
    repeat (8) @(negedge CLOCK);
    sw(1, 0, 0, 0, 8'h00);
    sw(1, 1, 0, 0, 8'h00);
    chk({6'h00, GO, DONE}, 8'h00);
    chk(RESULT, last);
    repeat (12) @(negedge CLOCK);
    chk({7'h00, SAMPLE}, 8'h01);
    sw(0, 0, 0, 1, 8'h3c);
    chk(RESULT, 8'h3c);
    CLK_SEL_RC = 1'b0; // Divider path: two clocks, then zero taken as one.
    for (int i = 0; i < 2; i++) begin
      CLK_DIV = 8'h02 >> (2 * i);
      PERIOD  = 8'h02 >> i;
      repeat (20) @(negedge CLOCK);
      conv(3'h7);
    end
    final_report();
  end
endmodule // acc_conversion_control_test
`default_nettype wire
